/* rtl/efc_pkg.sv */
`default_nettype none

package efc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ST_W   = 93;
  localparam int NPINS  = 3;
  localparam int NPORTS = 2;

  localparam logic [ADDR_W-1:0] OFF_FREEZE_CTL = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_LOG_PORT   = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_FES_W0     = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_FES_W1     = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_FES_W2     = 8'h88;

  localparam int FRZ_COR     = 0;
  localparam int FRZ_NCO     = 1;
  localparam int FRZ_FTL     = 2;
  localparam int FRZ_RSV_LSB = 4;
  localparam logic [4:0] FRZ_RSV_VAL = 5'h1F;
  localparam logic [2:0] FRZ_RESET   = 3'h0;

  localparam int LOG_FTL_BIT = 0;
  localparam int LOG_REC_BIT = 1;

  localparam int BIT_ILLEGAL  = 92;
  localparam int BIT_PROTOCOL = 91;
  localparam int BIT_BUS_INIT = 90;
  localparam int BIT_ADDR_PAR = 89;
  localparam int BIT_REQ_PAR  = 88;
  localparam int BIT_OUT_MBIT = 87;
  localparam int BIT_BUS_ERROR_SIGNAL_OBS = 85;
  localparam int BIT_SP_FTL   = 0;
  localparam int BIT_SP_UNC   = 2;
  localparam int BIT_SP_COR   = 4;

  localparam int PIN_COR = 0;
  localparam int PIN_UNC = 1;
  localparam int PIN_FTL = 2;

  localparam logic [ST_W-1:0] ONE = 93'h1;
  localparam logic [ST_W-1:0] FATAL_MASK = (ONE << BIT_ILLEGAL) | (ONE << BIT_PROTOCOL)
    | (ONE << BIT_BUS_INIT) | (ONE << BIT_ADDR_PAR) | (ONE << BIT_REQ_PAR)
    | (ONE << BIT_SP_FTL) | (ONE << (BIT_SP_FTL + 1));
  localparam logic [ST_W-1:0] UNC_MASK = (ONE << BIT_OUT_MBIT) | (ONE << BIT_BUS_ERROR_SIGNAL_OBS)
    | (ONE << BIT_SP_UNC) | (ONE << (BIT_SP_UNC + 1));
  localparam logic [ST_W-1:0] COR_MASK = (ONE << BIT_SP_COR) | (ONE << (BIT_SP_COR + 1));
  localparam logic [ST_W-1:0] REC_MASK = UNC_MASK | COR_MASK;
  localparam logic [ST_W-1:0] PIN_CLASS_MASK [NPINS] = '{COR_MASK, UNC_MASK, FATAL_MASK};

  localparam logic [2:0] SEEN_CYCLES = 3'h4;
  localparam logic [7:0] POISON_ECC_DEFAULT = 8'hFF;

endpackage

`default_nettype wire

/* rtl/efc_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface efc_pin_if;
  logic pin_n;
  logic sample_en;
  logic capture;
  logic clear_req;
  logic seen;
  logic already;

  modport watch (input pin_n, input sample_en, input capture, input clear_req,
                 output seen, output already);
  modport ctrl  (output pin_n, output sample_en, output capture, output clear_req,
                 input seen, input already);
endinterface

`default_nettype wire

/* rtl/efc_pin_watch.sv */
`timescale 1ns/1ps
`default_nettype none

module efc_pin_watch (
  input  wire logic   i_clk,
  input  wire logic   i_srst,
  input  wire logic   i_pwrup_srst,
  efc_pin_if.watch    pin
);

  logic       sync1_reg;
  logic       sync2_reg;
  logic [2:0] cnt_reg;
  logic       already_reg;

  // The pin is shared and open drain, so it is resynchronised before any use.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= ~pin.pin_n;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !pin.sample_en || !sync2_reg) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != efc_pkg::SEEN_CYCLES) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  assign pin.seen = (cnt_reg == efc_pkg::SEEN_CYCLES);

  // Only a power-up reset or a written one forgets which component drove the pin first.
  always_ff @(posedge i_clk) begin
    if (i_pwrup_srst) begin
      already_reg <= 1'b0;
    end else if (pin.capture && pin.seen) begin
      already_reg <= 1'b1;
    end else if (pin.clear_req) begin
      already_reg <= 1'b0;
    end
  end

  assign pin.already = already_reg;

  property p_latch_seen;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    (pin.capture && pin.seen) |=> already_reg;
  endproperty
  a_latch_seen: assert property (p_latch_seen) else $error("pin seen not latched");

  property p_no_self_clear;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    $fell(already_reg) |-> $past(pin.clear_req);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("already bit self cleared");

  property p_stop_sampling;
    @(posedge i_clk) disable iff (i_srst)
    !pin.sample_en [*2] |-> (cnt_reg == 3'h0) [*2];
  endproperty
  a_stop_sampling: assert property (p_stop_sampling) else $error("pin sampled while held");

  c_seen_latched: cover property (@(posedge i_clk) pin.capture && pin.seen);

endmodule

`default_nettype wire

/* rtl/efc_top.sv */
// Overview of operation
// - Fatal freeze bit set: fatal error or pin freezes processor and port interfaces.
// - Non-correctable freeze bit set: uncorrectable error or pin freezes the interfaces.
// - Correctable freeze bit set: correctable error or pin freezes; freeze bits reset zero.
// - Every error is fatal, uncorrectable or correctable for flagging and logging.
// - At most one fatal and one recoverable first error are recorded.
// - Simultaneous errors of one type: only the most significant bit is flagged.
// - Log of a captured type holds until its status bit clears or power-up.
// - A port-detected first error records which scalability port holds the log.
// - First error of a type latches that type's error pin value.
// - Fatal pin asserted four cycles before own first fatal drive sets a flag.
// - Uncorrectable pin asserted four cycles before own drive sets a flag.
// - Correctable pin asserted four cycles before own drive sets a flag.
// - Fatal pin sampling stops at capture, resumes when all fatal bits clear.
// - Uncorrectable pin sampling resumes once all uncorrectable bits are clear.
// - Correctable pin sampling resumes once all correctable bits are clear.
// - Pin-already flags never self-clear; a written one clears them.
// - Illegal or unsupported bus transaction flags a fatal error.
// - Modified-line hit on explicit write-back flags a fatal protocol error.
// - Any agent asserting the bus init signal flags a fatal error.
// - Address parity error is fatal, yet a clean request still completes.
// - Request signal parity error flags a fatal error.
// - Outbound multi-bit data error: flag uncorrectable, poison check bits, forward.
// - Bus error signal seen but not driven by this device sets a flag.
`timescale 1ns/1ps
`default_nettype none

module efc_top #(
  parameter logic [7:0] POISON_ECC = efc_pkg::POISON_ECC_DEFAULT
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_pwrup_srst,
  input  wire logic [efc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [efc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [efc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                       i_req_valid,
  input  wire logic                       i_req_parity_err,
  input  wire logic                       i_addr_parity_err,
  input  wire logic                       i_illegal_txn,
  input  wire logic                       i_explicit_wb,
  input  wire logic                       i_modified_line_hit,
  input  wire logic                       i_bus_init_signal_n,
  input  wire logic                       i_bus_error_signal_n,
  input  wire logic                       i_bus_error_own,
  input  wire logic [efc_pkg::NPORTS-1:0] i_sp_fatal_err,
  input  wire logic [efc_pkg::NPORTS-1:0] i_sp_unc_err,
  input  wire logic [efc_pkg::NPORTS-1:0] i_sp_cor_err,
  input  wire logic                       i_out_valid,
  input  wire logic [63:0]                i_out_data,
  input  wire logic [7:0]                 i_out_ecc,
  input  wire logic                       i_out_mbit_err,
  input  wire logic                       i_out_firmware_hub,
  output logic                            o_fwd_valid,
  output logic      [63:0]                o_fwd_data,
  output logic      [7:0]                 o_fwd_ecc,
  output logic                            o_fwd_firmware_hub,
  output logic                            o_req_complete,
  output logic                            o_freeze,
  input  wire logic [efc_pkg::NPINS-1:0]  i_err_pin_n,
  output logic      [efc_pkg::NPINS-1:0]  o_err_pin_o,
  output logic      [efc_pkg::NPINS-1:0]  o_err_pin_oe
);

  localparam int ST_W = efc_pkg::ST_W;

  logic [2:0]                      frz_ctl_reg;
  logic [ST_W-1:0]                 stat_reg;
  logic [ST_W-1:0]                 stat_next;
  logic [ST_W-1:0]                 ev;
  logic [ST_W-1:0]                 fat_set;
  logic [ST_W-1:0]                 rec_set;
  logic [95:0]                     clr_full;
  logic [95:0]                     full_view;
  logic                            ftl_port_reg;
  logic                            rec_port_reg;
  logic                            freeze_reg;
  logic                            frz_trig;
  logic [efc_pkg::NPINS-1:0]       oe_reg;
  logic [efc_pkg::NPINS-1:0]       cap;
  logic [efc_pkg::NPINS-1:0]       seen;
  logic [efc_pkg::NPINS-1:0]       already;
  logic [efc_pkg::DATA_W-1:0]      rdata_reg;
  logic                            init_s1_reg;
  logic                            init_s2_reg;
  logic                            bus_error_signal_s1_reg;
  logic                            bus_error_signal_s2_reg;
  logic [1:0]                      own_dly_reg;
  logic                            fwd_valid_reg;
  logic [63:0]                     fwd_data_reg;
  logic [7:0]                      fwd_ecc_reg;
  logic                            fwd_fwh_reg;
  logic                            fat_empty;
  logic                            rec_empty;

  function automatic logic [ST_W-1:0] msb_only(input logic [ST_W-1:0] v);
    logic [ST_W-1:0] r;
    logic            found;
    r     = '0;
    found = 1'b0;
    for (int i = ST_W - 1; i >= 0; i--) begin
      if (v[i] && !found) begin
        r[i]  = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // Bus-side pins from other agents are resynchronised before use.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      init_s1_reg <= 1'b0;
      init_s2_reg <= 1'b0;
      bus_error_signal_s1_reg <= 1'b0;
      bus_error_signal_s2_reg <= 1'b0;
      own_dly_reg <= 2'h0;
    end else begin
      init_s1_reg <= ~i_bus_init_signal_n;
      init_s2_reg <= init_s1_reg;
      bus_error_signal_s1_reg <= ~i_bus_error_signal_n;
      bus_error_signal_s2_reg <= bus_error_signal_s1_reg;
      // Own drive is delayed to line up with the synchronised pin level.
      own_dly_reg <= {own_dly_reg[0], i_bus_error_own};
    end
  end

  always_comb begin
    ev = '0;
    ev[efc_pkg::BIT_ILLEGAL]  = i_illegal_txn;
    ev[efc_pkg::BIT_PROTOCOL] = i_explicit_wb && i_modified_line_hit;
    ev[efc_pkg::BIT_BUS_INIT] = init_s2_reg;
    ev[efc_pkg::BIT_ADDR_PAR] = i_req_valid && i_addr_parity_err;
    ev[efc_pkg::BIT_REQ_PAR]  = i_req_valid && i_req_parity_err;
    ev[efc_pkg::BIT_OUT_MBIT] = i_out_valid && i_out_mbit_err;
    ev[efc_pkg::BIT_BUS_ERROR_SIGNAL_OBS] = bus_error_signal_s2_reg && !own_dly_reg[1];
    for (int k = 0; k < efc_pkg::NPORTS; k++) begin
      ev[efc_pkg::BIT_SP_FTL + k] = i_sp_fatal_err[k];
      ev[efc_pkg::BIT_SP_UNC + k] = i_sp_unc_err[k];
      ev[efc_pkg::BIT_SP_COR + k] = i_sp_cor_err[k];
    end
  end

  // A new first error is taken only while its type holds none.
  assign fat_empty = ((stat_reg & efc_pkg::FATAL_MASK) == '0);
  assign rec_empty = ((stat_reg & efc_pkg::REC_MASK) == '0);
  assign fat_set = fat_empty ? msb_only(ev & efc_pkg::FATAL_MASK) : '0;
  assign rec_set = rec_empty ? msb_only(ev & efc_pkg::REC_MASK) : '0;

  // Status write-one-to-clear, word by word.
  always_comb begin
    clr_full = '0;
    if (i_wr) begin
      unique case (i_addr)
        efc_pkg::OFF_FES_W0: clr_full[31:0]  = i_wdata;
        efc_pkg::OFF_FES_W1: clr_full[63:32] = i_wdata;
        efc_pkg::OFF_FES_W2: clr_full[95:64] = i_wdata;
        default:             clr_full        = '0;
      endcase
    end
  end

  // A set in the same cycle as its clear wins, but an error in the cycle that clears its type's held one is not taken.
  assign stat_next = (stat_reg & ~clr_full[ST_W-1:0]) | fat_set | rec_set;

  always_ff @(posedge i_clk) begin
    if (i_pwrup_srst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Port log pointers only move on a new capture of their type.
  always_ff @(posedge i_clk) begin
    if (i_pwrup_srst) begin
      ftl_port_reg <= 1'b0;
      rec_port_reg <= 1'b0;
    end else begin
      if (fat_set[efc_pkg::BIT_SP_FTL +: efc_pkg::NPORTS] != '0) begin
        ftl_port_reg <= fat_set[efc_pkg::BIT_SP_FTL + 1];
      end
      if ((rec_set[efc_pkg::BIT_SP_UNC +: efc_pkg::NPORTS] != '0)
          || (rec_set[efc_pkg::BIT_SP_COR +: efc_pkg::NPORTS] != '0)) begin
        rec_port_reg <= rec_set[efc_pkg::BIT_SP_UNC + 1]
                     || rec_set[efc_pkg::BIT_SP_COR + 1];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_pwrup_srst) begin
      frz_ctl_reg <= efc_pkg::FRZ_RESET;
    end else if (i_wr && (i_addr == efc_pkg::OFF_FREEZE_CTL)) begin
      frz_ctl_reg <= i_wdata[2:0];
    end
  end

  // Pins seen asserted also freeze: another agent may have found the error.
  assign frz_trig =
      (frz_ctl_reg[efc_pkg::FRZ_FTL] && (((ev & efc_pkg::FATAL_MASK) != '0)
        || seen[efc_pkg::PIN_FTL]))
   || (frz_ctl_reg[efc_pkg::FRZ_NCO] && (((ev & efc_pkg::UNC_MASK) != '0)
        || seen[efc_pkg::PIN_UNC]))
   || (frz_ctl_reg[efc_pkg::FRZ_COR] && (((ev & efc_pkg::COR_MASK) != '0)
        || seen[efc_pkg::PIN_COR]));

  // Freeze holds until a reset; software cannot thaw a stopped interface.
  always_ff @(posedge i_clk) begin
    if (i_srst || i_pwrup_srst) begin
      freeze_reg <= 1'b0;
    end else if (frz_trig) begin
      freeze_reg <= 1'b1;
    end
  end

  assign o_freeze = freeze_reg;
  assign o_req_complete = i_req_valid && !i_req_parity_err && !freeze_reg;

  // Error pins: driven low while the matching class holds a first error.
  always_ff @(posedge i_clk) begin
    if (i_pwrup_srst) begin
      oe_reg <= '0;
    end else begin
      for (int k = 0; k < efc_pkg::NPINS; k++) begin
        oe_reg[k] <= ((stat_next & efc_pkg::PIN_CLASS_MASK[k]) != '0);
      end
    end
  end

  assign o_err_pin_oe = oe_reg;
  assign o_err_pin_o  = '0;

  generate
    for (genvar g = 0; g < efc_pkg::NPINS; g++) begin : g_pin
      efc_pin_if pif ();
      assign pif.pin_n     = i_err_pin_n[g];
      assign pif.sample_en = ((stat_reg & efc_pkg::PIN_CLASS_MASK[g]) == '0);
      assign pif.capture   = (((fat_set | rec_set) & efc_pkg::PIN_CLASS_MASK[g]) != '0);
      assign pif.clear_req = clr_full[ST_W + g];
      assign seen[g]       = pif.seen;
      assign already[g]    = pif.already;
      assign cap[g]        = pif.capture;
      efc_pin_watch u_watch (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_pwrup_srst (i_pwrup_srst),
        .pin          (pif.watch)
      );
    end
  endgenerate

  // Outbound data always goes on; a bad word is marked rather than dropped.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fwd_valid_reg <= 1'b0;
      fwd_data_reg  <= 64'h0;
      fwd_ecc_reg   <= 8'h00;
      fwd_fwh_reg   <= 1'b0;
    end else begin
      fwd_valid_reg <= i_out_valid;
      fwd_data_reg  <= i_out_data;
      fwd_ecc_reg   <= i_out_mbit_err ? POISON_ECC : i_out_ecc;
      fwd_fwh_reg   <= i_out_firmware_hub;
    end
  end

  assign o_fwd_valid        = fwd_valid_reg;
  assign o_fwd_data         = fwd_data_reg;
  assign o_fwd_ecc          = fwd_ecc_reg;
  assign o_fwd_firmware_hub = fwd_fwh_reg;

  assign full_view = {already, stat_reg};

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        efc_pkg::OFF_FREEZE_CTL: begin
          rdata_reg <= '0;
          rdata_reg[2:0] <= frz_ctl_reg;
          rdata_reg[efc_pkg::FRZ_RSV_LSB +: 5] <= efc_pkg::FRZ_RSV_VAL;
        end
        efc_pkg::OFF_LOG_PORT: begin
          rdata_reg <= '0;
          rdata_reg[efc_pkg::LOG_FTL_BIT] <= ftl_port_reg;
          rdata_reg[efc_pkg::LOG_REC_BIT] <= rec_port_reg;
        end
        efc_pkg::OFF_FES_W0: rdata_reg <= full_view[31:0];
        efc_pkg::OFF_FES_W1: rdata_reg <= full_view[63:32];
        efc_pkg::OFF_FES_W2: rdata_reg <= full_view[95:64];
        default:             rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign o_rdata = rdata_reg;

  property p_frz_ftl;
    @(posedge i_clk) disable iff (i_srst || i_pwrup_srst)
    (frz_ctl_reg[efc_pkg::FRZ_FTL] && i_illegal_txn) |=> o_freeze [*3];
  endproperty
  a_frz_ftl: assert property (p_frz_ftl) else $error("no freeze on fatal");

  property p_frz_nco;
    @(posedge i_clk) disable iff (i_srst || i_pwrup_srst)
    (frz_ctl_reg[efc_pkg::FRZ_NCO] && i_out_valid && i_out_mbit_err) |=> o_freeze;
  endproperty
  a_frz_nco: assert property (p_frz_nco) else $error("no freeze on uncorrectable");

  property p_frz_cor;
    @(posedge i_clk) disable iff (i_srst || i_pwrup_srst)
    (frz_ctl_reg == 3'h1 && !seen[efc_pkg::PIN_FTL] && !seen[efc_pkg::PIN_UNC]
      && !seen[efc_pkg::PIN_COR] && (ev == '0) && !o_freeze) |=> !o_freeze;
  endproperty
  a_frz_cor: assert property (p_frz_cor) else $error("freeze without cause");

  property p_one_each;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    $onehot0(stat_reg & efc_pkg::FATAL_MASK) && $onehot0(stat_reg & efc_pkg::REC_MASK);
  endproperty
  a_one_each: assert property (p_one_each) else $error("more than one first error");

  property p_msb_wins;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    (fat_empty && ev[efc_pkg::BIT_PROTOCOL] && ev[efc_pkg::BIT_REQ_PAR] && !i_illegal_txn)
      |=> stat_reg[efc_pkg::BIT_PROTOCOL] && !stat_reg[efc_pkg::BIT_REQ_PAR];
  endproperty
  a_msb_wins: assert property (p_msb_wins) else $error("lower error flagged");

  property p_log_hold;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    (!fat_empty ##1 !fat_empty) |-> $stable(ftl_port_reg);
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("fatal log moved");

  property p_bus_init;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    (init_s2_reg && fat_empty && !i_illegal_txn && !ev[efc_pkg::BIT_PROTOCOL])
      |=> stat_reg[efc_pkg::BIT_BUS_INIT];
  endproperty
  a_bus_init: assert property (p_bus_init) else $error("bus init not flagged");

  property p_bus_error_signal_obs;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    (rec_empty && bus_error_signal_s2_reg && !own_dly_reg[1] && !ev[efc_pkg::BIT_OUT_MBIT])
      |=> stat_reg[efc_pkg::BIT_BUS_ERROR_SIGNAL_OBS];
  endproperty
  a_bus_error_signal_obs: assert property (p_bus_error_signal_obs) else $error("bus error not flagged");

  property p_poison;
    @(posedge i_clk) disable iff (i_srst)
    (i_out_valid && i_out_mbit_err) |=> (o_fwd_valid && o_fwd_ecc == POISON_ECC);
  endproperty
  a_poison: assert property (p_poison) else $error("bad data not poisoned");

  property p_req_done;
    @(posedge i_clk) disable iff (i_srst || i_pwrup_srst)
    (i_req_valid && i_addr_parity_err && !i_req_parity_err && !o_freeze) |-> o_req_complete;
  endproperty
  a_req_done: assert property (p_req_done) else $error("clean request dropped");

  property p_pin_drive;
    @(posedge i_clk) disable iff (i_pwrup_srst)
    cap[efc_pkg::PIN_FTL] |=> o_err_pin_oe[efc_pkg::PIN_FTL];
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("fatal pin not driven");

  c_freeze: cover property (@(posedge i_clk) $rose(o_freeze));
  c_both_first: cover property (@(posedge i_clk) !fat_empty && !rec_empty);
  c_bus_error_signal: cover property (@(posedge i_clk) ev[efc_pkg::BIT_BUS_ERROR_SIGNAL_OBS]);
  c_poison: cover property (@(posedge i_clk) i_out_valid && i_out_mbit_err);

endmodule

`default_nettype wire

/* sim/efc_agent_model.sv */
`timescale 1ns/1ps
`default_nettype none

module efc_agent_model (
  input  wire logic [2:0] i_drive,
  input  wire logic [2:0] i_dut_oe,
  output logic      [2:0] o_pin_n
);
  // Pull-ups hold each shared pin high; any agent pulling it wins, so no last value lingers.
  assign o_pin_n = ~(i_drive | i_dut_oe);
endmodule

`default_nettype wire

/* sim/error_first_capture_freeze_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module error_first_capture_freeze_tb_top;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_pwrup_srst = 1'b1;
  logic [7:0]  i_addr = 8'h00, i_out_ecc = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_req_valid = 1'b0, i_req_parity_err = 1'b0;
  logic        i_addr_parity_err = 1'b0, i_illegal_txn = 1'b0, i_explicit_wb = 1'b0;
  logic        i_modified_line_hit = 1'b0, i_bus_init_signal_n = 1'b1;
  logic        i_bus_error_signal_n = 1'b1, i_out_valid = 1'b0, i_out_mbit_err = 1'b0;
  logic        i_out_firmware_hub = 1'b0;
  logic [1:0]  i_sp_fatal_err = 2'h0, i_sp_unc_err = 2'h0, i_sp_cor_err = 2'h0;
  logic        i_bus_error_own = 1'b0;
  logic [63:0] i_out_data = 64'h0, o_fwd_data;
  logic        o_fwd_valid, o_fwd_firmware_hub, o_req_complete, o_freeze;
  logic [7:0]  o_fwd_ecc;
  logic [2:0]  i_err_pin_n, o_err_pin_o, o_err_pin_oe, drive = 3'h0;
  int          num_errors = 0, compares = 0, cyc = 0;

  always #5 i_clk = ~i_clk;

  efc_top #(.POISON_ECC(8'hA5)) DUT (
    .i_clk, .i_srst, .i_pwrup_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_req_valid, .i_req_parity_err, .i_addr_parity_err, .i_illegal_txn, .i_explicit_wb,
    .i_modified_line_hit, .i_bus_init_signal_n, .i_bus_error_signal_n,
    .i_bus_error_own, .i_sp_fatal_err, .i_sp_unc_err, .i_sp_cor_err,
    .i_out_valid, .i_out_data, .i_out_ecc, .i_out_mbit_err, .i_out_firmware_hub,
    .o_fwd_valid, .o_fwd_data, .o_fwd_ecc, .o_fwd_firmware_hub, .o_req_complete,
    .o_freeze, .i_err_pin_n, .o_err_pin_o, .o_err_pin_oe
  );

  efc_agent_model AGENT (.i_drive(drive), .i_dut_oe(o_err_pin_oe), .o_pin_n(i_err_pin_n));

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    tick(6); i_srst <= 1'b0; i_pwrup_srst <= 1'b0;
    rd(8'h40, 32'h1F0);
    rd(8'h88, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h40, 32'h4);
    tick(1); i_illegal_txn <= 1'b1; tick(1); i_illegal_txn <= 1'b0; tick(1);
    #1 chk(o_freeze, 1);
    chk(o_err_pin_oe, 3'h4);
    chk(o_err_pin_o, 3'h0);
    rd(8'h88, 32'h1000_0000);
    tick(1); i_req_valid <= 1'b1; i_req_parity_err <= 1'b1; tick(1);
    i_req_valid <= 1'b0; i_req_parity_err <= 1'b0;
    rd(8'h88, 32'h1000_0000);
    tick(1); i_srst <= 1'b1; tick(3); i_srst <= 1'b0; tick(1);
    #1 chk(o_freeze, 0);
    rd(8'h88, 32'h1000_0000);
    wr(8'h88, 32'h1000_0000);
    rd(8'h88, 32'h0);
    // Two fatal sources in one cycle: only the higher status bit may be kept.
    tick(1); i_req_valid <= 1'b1; i_req_parity_err <= 1'b1;
    i_explicit_wb <= 1'b1; i_modified_line_hit <= 1'b1;
    #1 chk(o_req_complete, 0);
    tick(1); i_req_valid <= 1'b0; i_req_parity_err <= 1'b0;
    i_explicit_wb <= 1'b0; i_modified_line_hit <= 1'b0;
    rd(8'h88, 32'h0800_0000);
    chk(o_freeze, 0);
    wr(8'h88, 32'h0800_0000);
    tick(1); i_req_valid <= 1'b1; i_addr_parity_err <= 1'b1;
    #1 chk(o_req_complete, 1);
    tick(1); i_req_valid <= 1'b0; i_addr_parity_err <= 1'b0;
    rd(8'h88, 32'h0200_0000);
    wr(8'h88, 32'h0200_0000);
    tick(1); i_bus_init_signal_n <= 1'b0; tick(4); i_bus_init_signal_n <= 1'b1; tick(4);
    rd(8'h88, 32'h0400_0000);
    wr(8'h88, 32'h0400_0000);
    tick(1); i_sp_fatal_err <= 2'h2; tick(1); i_sp_fatal_err <= 2'h0;
    rd(8'h80, 32'h2);
    rd(8'h44, 32'h1);
    wr(8'h80, 32'h2);
    tick(1); drive <= 3'h4; tick(8); i_illegal_txn <= 1'b1; tick(1);
    i_illegal_txn <= 1'b0; drive <= 3'h0;
    rd(8'h88, 32'h9000_0000);
    wr(8'h88, 32'h1000_0000);
    rd(8'h88, 32'h8000_0000);
    wr(8'h88, 32'h8000_0000);
    rd(8'h88, 32'h0);
    wr(8'h40, 32'h2);
    tick(1); i_out_valid <= 1'b1; i_out_data <= 64'h0123_4567_89AB_CDEF;
    i_out_ecc <= 8'h3C; i_out_mbit_err <= 1'b1; i_out_firmware_hub <= 1'b1;
    tick(1); i_out_valid <= 1'b0; i_out_mbit_err <= 1'b0; i_out_firmware_hub <= 1'b0;
    #1 chk(o_fwd_data, 64'h0123_4567_89AB_CDEF);
    chk({o_fwd_valid, o_fwd_firmware_hub, o_fwd_ecc}, 10'h3A5);
    tick(1); #1 chk(o_freeze, 1);
    rd(8'h88, 32'h0080_0000);
    wr(8'h88, 32'h0080_0000);
    // Our own drive of the bus error pin must not be reported as observed.
    tick(1); i_bus_error_own <= 1'b1; i_bus_error_signal_n <= 1'b0; tick(4);
    i_bus_error_own <= 1'b0; i_bus_error_signal_n <= 1'b1; tick(4);
    rd(8'h88, 32'h0);
    tick(1); i_bus_error_signal_n <= 1'b0; tick(4); i_bus_error_signal_n <= 1'b1; tick(4);
    rd(8'h88, 32'h0020_0000);
    wr(8'h88, 32'h0020_0000);
    tick(1); i_sp_unc_err <= 2'h1; tick(1); i_sp_unc_err <= 2'h0;
    rd(8'h80, 32'h4);
    wr(8'h80, 32'h4);
    tick(1); i_srst <= 1'b1; tick(3); i_srst <= 1'b0;
    wr(8'h40, 32'h1);
    tick(1); drive <= 3'h1; tick(8); i_sp_cor_err <= 2'h2; tick(1);
    i_sp_cor_err <= 2'h0; drive <= 3'h0; tick(1);
    #1 chk(o_freeze, 1);
    rd(8'h88, 32'h2000_0000);
    rd(8'h80, 32'h20);
    rd(8'h44, 32'h3);
    wrap_up();
  end
endmodule

`default_nettype wire
